// >>> chg_pkg.sv
package chg_pkg;

    // register command codes
    localparam logic [7:0]  INPUT_LIMIT_ADDR  = 8'h3f;
    localparam logic [7:0]  CHARGE_AMPS_ADDR  = 8'h14;
    localparam logic [7:0]  CHARGE_VOLTS_ADDR = 8'h15;
    localparam logic [7:0]  MFR_ID_ADDR       = 8'hfe;
    localparam logic [7:0]  DEV_ID_ADDR       = 8'hff;

    // input limit word layout and reset value
    localparam int          FIELD_LSB         = 7;
    localparam int          FIELD_W           = 6;
    localparam logic [15:0] INPUT_LIMIT_RST   = 16'h0080;
    localparam logic [15:0] CHARGE_RST        = 16'h0000;

    // limit figures in mA
    localparam logic [15:0] LIMIT_STEP_MA     = 16'h0100;
    localparam logic [15:0] LIMIT_CAP_MA      = 16'h2afc;

    // watchdog time in seconds and clock rate
    localparam longint      WDOG_TIME_S       = 175;
    localparam longint      CLK_HZ            = 125000000;
    localparam longint      WDOG_CYCLES       = WDOG_TIME_S * CLK_HZ;

    typedef enum logic [2:0] {
        CHG_POR  = 3'b001,
        CHG_IDLE = 3'b010,
        CHG_RUN  = 3'b100
    } chg_state_e;

endpackage : chg_pkg

// >>> chg_limit_reg.sv
`timescale 1ns/1ps
// one 16-bit setting word with registered read data
module chg_limit_reg #(
    parameter logic [15:0] RESET_VALUE = 16'h0000
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        wr_en,
    input  wire logic [15:0] wr_data,
    output logic      [15:0] rd_data
);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= RESET_VALUE;
        end else if (ce && wr_en) begin
            rd_data <= wr_data;
        end
    end

endmodule : chg_limit_reg

// >>> chg_ctrl.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - input limit field bits 7..12 weigh 256..8192 mA and are summed.
// - bits 0..6 and 13..15 of the input limit word only pick 0 or 256 mA when bits 7..12 are zero.
// - the effective input limit never exceeds 11004 mA.
// - the adapter-good pin floats while adapter detect is high, else low.
// - charging is allowed only while main input is above 7.5 V.
// - a zero charge current or charge voltage setting stops charging.
// - power-fail (sense dropout within 10 mV) blocks charging.
// - all registers sit at reset values while the interface supply is low.
// - no write is accepted while the interface supply is low.
// - after reset, both charge settings must be written before charging.
// - written settings persist whenever the interface supply stays good.
// - charging needs main input, regulator and reference good flags.
// - charging needs the 210 mV sense headroom flag (15 mV hysteresis).
// - limits 1..256 mA act as 256 mA, and reset gives 256 mA.
// - no charge setting write for 175 s ends charging until both rewrite.
//////////////////////////////////////////////////////////////////////////////
module chg_ctrl #(
    parameter longint WDOG_CYCLES = chg_pkg::WDOG_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        ce,
    input  wire logic        vdd_good,
    input  wire logic        wr_en,
    input  wire logic [7:0]  wr_cmd,
    input  wire logic [15:0] wr_data,
    input  wire logic        adapter_detect_input,
    input  wire logic        main_input_supply_good,
    input  wire logic        gate_driver_regulator_good,
    input  wire logic        reference_good,
    input  wire logic        headroom_ok,
    input  wire logic        power_fail,
    output logic      [15:0] input_limit_ma,
    output logic      [5:0]  input_limit_field,
    output logic             charge_enable,
    output logic             adapter_good_out_o,
    output logic             adapter_good_out_oe,
    output logic             timed_out
);

    //////////////////////////////////////////////////////////////////////////
    // reset release and supply-good qualification
    logic       rst_meta;
    logic       rst_sync;
    logic [1:0] vdd_sync;
    logic       rst_n;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            vdd_sync <= 2'b00;
        end else begin
            vdd_sync <= {vdd_sync[0], vdd_good};
        end
    end

    // supply undervoltage holds every register at reset
    assign rst_n = rst_sync & vdd_sync[1];

    //////////////////////////////////////////////////////////////////////////
    // flag synchronisers
    localparam int NFLAG = 6;
    logic [NFLAG-1:0] flag_raw;
    logic [NFLAG-1:0] flag_meta;
    logic [NFLAG-1:0] flag_sync;

    assign flag_raw = {power_fail, headroom_ok, reference_good,
                       gate_driver_regulator_good, main_input_supply_good,
                       adapter_detect_input};

    genvar gi;
    generate
        for (gi = 0; gi < NFLAG; gi++) begin : g_sync
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    flag_meta[gi] <= 1'b0;
                    flag_sync[gi] <= 1'b0;
                end else if (ce) begin
                    flag_meta[gi] <= flag_raw[gi];
                    flag_sync[gi] <= flag_meta[gi];
                end
            end
        end
    endgenerate

    // positions of the flags in flag_raw
    localparam int F_ADAPTER = 0;
    localparam int F_MAIN    = 1;
    localparam int F_REG     = 2;
    localparam int F_REF     = 3;
    localparam int F_HEAD    = 4;
    localparam int F_PFAIL   = 5;

    wire adapter_s = flag_sync[F_ADAPTER];
    wire main_s    = flag_sync[F_MAIN];
    wire reg_s     = flag_sync[F_REG];
    wire ref_s     = flag_sync[F_REF];
    wire head_s    = flag_sync[F_HEAD];
    wire pfail_s   = flag_sync[F_PFAIL];

    //////////////////////////////////////////////////////////////////////////
    // write decode
    function automatic logic hit(input logic [7:0] cmd,
                                 input logic [7:0] addr);
        hit = (cmd == addr);
    endfunction : hit

    wire wr_ok      = wr_en & ce;
    wire wr_limit   = wr_ok & hit(wr_cmd, chg_pkg::INPUT_LIMIT_ADDR);
    wire wr_amps    = wr_ok & hit(wr_cmd, chg_pkg::CHARGE_AMPS_ADDR);
    wire wr_volts   = wr_ok & hit(wr_cmd, chg_pkg::CHARGE_VOLTS_ADDR);

    //////////////////////////////////////////////////////////////////////////
    // setting registers, kept while supply is good
    logic [15:0] input_limit_word;
    logic [15:0] charge_amps_setting;
    logic [15:0] charge_volts_setting;

    chg_limit_reg #(
        .RESET_VALUE (chg_pkg::INPUT_LIMIT_RST)
    ) u_limit (
        .clk     (clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .wr_en   (wr_limit),
        .wr_data (wr_data),
        .rd_data (input_limit_word)
    );

    // charge settings clear at reset, so charging waits for both writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            charge_amps_setting <= chg_pkg::CHARGE_RST;
        end else if (ce && wr_amps) begin
            charge_amps_setting <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            charge_volts_setting <= chg_pkg::CHARGE_RST;
        end else if (ce && wr_volts) begin
            charge_volts_setting <= wr_data;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // input limit decode
    localparam int FLSB = chg_pkg::FIELD_LSB;
    localparam int FW   = chg_pkg::FIELD_W;
    localparam logic [5:0] FIELD_RST = chg_pkg::INPUT_LIMIT_RST[FLSB +: FW];

    // bits 12..7 of the word set the limit; the other bits count only when those are zero
    wire [5:0]  field        = input_limit_word[FLSB +: FW];
    // bit 7 weighs 256 mA and each bit above doubles: sum is field * 256
    wire [15:0] limit_sum    = {2'b00, field, 8'h00};
    // a nonzero word below one step still gives one step
    wire        below_step   = (field == 6'h00);
    wire        word_nonzero = (input_limit_word != 16'h0000);
    wire        low_word     = below_step & word_nonzero;
    wire [15:0] limit_floor  = low_word ? chg_pkg::LIMIT_STEP_MA
                                        : limit_sum;
    wire        over_cap     = (limit_floor > chg_pkg::LIMIT_CAP_MA);
    wire [15:0] limit_eff    = over_cap ? chg_pkg::LIMIT_CAP_MA
                                        : limit_floor;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            input_limit_ma    <= chg_pkg::LIMIT_STEP_MA;
            input_limit_field <= FIELD_RST;
        end else if (ce) begin
            input_limit_ma    <= limit_eff;
            input_limit_field <= field;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // write-both tracking and watchdog
    localparam int WDW = $clog2(WDOG_CYCLES + 1);
    localparam logic [WDW-1:0] WD_LAST = WDW'(WDOG_CYCLES - 1);
    logic [WDW-1:0] wdog_cnt;
    logic           got_amps;
    logic           got_volts;
    wire            any_chg_wr = wr_amps | wr_volts;
    wire            wdog_end   = (wdog_cnt == WD_LAST);
    wire            wdog_fire  = wdog_end & ~any_chg_wr;
    wire            both_got   = got_amps & got_volts;
    // a write in the timeout cycle wins over the clear
    wire            next_got_amps  = wr_amps | (got_amps & ~wdog_fire);
    wire            next_got_volts = wr_volts | (got_volts & ~wdog_fire);

    // counts cycles since the last charge setting write or timeout
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wdog_cnt <= '0;
        end else if (ce) begin
            if (any_chg_wr || wdog_fire) begin
                wdog_cnt <= '0;
            end else begin
                wdog_cnt <= wdog_cnt + WDW'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            got_amps  <= 1'b0;
            got_volts <= 1'b0;
            timed_out <= 1'b0;
        end else if (ce) begin
            got_amps  <= next_got_amps;
            got_volts <= next_got_volts;
            if (wdog_fire) begin
                timed_out <= 1'b1;
            end else if (both_got) begin
                timed_out <= 1'b0;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // charge qualification
    chg_pkg::chg_state_e state;
    chg_pkg::chg_state_e next_state;

    wire supplies_ok = main_s & reg_s & ref_s;
    wire sense_ok    = head_s & ~pfail_s;
    wire amps_set    = (charge_amps_setting != 16'h0000);
    wire volts_set   = (charge_volts_setting != 16'h0000);
    wire settings_ok = amps_set & volts_set;
    wire armed       = both_got;
    wire qualify     = supplies_ok & sense_ok & settings_ok & armed;

    always_comb begin
        next_state = state;
        case (state)
            chg_pkg::CHG_POR: begin
                if (armed) begin
                    next_state = chg_pkg::CHG_IDLE;
                end
            end
            chg_pkg::CHG_IDLE: begin
                if (!armed) begin
                    next_state = chg_pkg::CHG_POR;
                end else if (qualify) begin
                    next_state = chg_pkg::CHG_RUN;
                end
            end
            chg_pkg::CHG_RUN: begin
                if (!armed) begin
                    next_state = chg_pkg::CHG_POR;
                end else if (!qualify) begin
                    next_state = chg_pkg::CHG_IDLE;
                end
            end
            default: begin
                next_state = chg_pkg::CHG_POR;
            end
        endcase
    end

    // charging only in the run state; a zero setting leaves run at once
    wire next_charge_enable = (next_state == chg_pkg::CHG_RUN);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state         <= chg_pkg::CHG_POR;
            charge_enable <= 1'b0;
        end else if (ce) begin
            state         <= next_state;
            charge_enable <= next_charge_enable;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // adapter-good open-drain pin
    // the pin only ever pulls low; released while the adapter is detected
    wire next_pin_oe = ~adapter_s;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            adapter_good_out_o  <= 1'b0;
            adapter_good_out_oe <= 1'b1;
        end else if (ce) begin
            adapter_good_out_o  <= 1'b0;
            adapter_good_out_oe <= next_pin_oe;
        end
    end

endmodule : chg_ctrl

// >>> chg_ctrl_properties.sv
`timescale 1ns/1ps
module chg_ctrl_properties #(
    parameter longint WDOG_CYCLES = 50
) (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        ce,
    input wire logic        vdd_good,
    input wire logic        wr_en,
    input wire logic [7:0]  wr_cmd,
    input wire logic [15:0] wr_data,
    input wire logic        adapter_detect_input,
    input wire logic        main_input_supply_good,
    input wire logic        gate_driver_regulator_good,
    input wire logic        reference_good,
    input wire logic        headroom_ok,
    input wire logic        power_fail,
    input wire logic [15:0] input_limit_ma,
    input wire logic [5:0]  input_limit_field,
    input wire logic        charge_enable,
    input wire logic        adapter_good_out_o,
    input wire logic        adapter_good_out_oe,
    input wire logic        timed_out
);
    wire logic bad = !main_input_supply_good || !gate_driver_regulator_good
        || !reference_good || !headroom_ok || power_fail;
    wire logic wr_lim = wr_en && ce && vdd_good && wr_cmd == 8'h3f;
    wire logic wr_zero = wr_en && ce && vdd_good && wr_data == 16'h0000
        && (wr_cmd == 8'h14 || wr_cmd == 8'h15);
    wire logic [5:0]  field_in = wr_data[12:7];
    wire logic [15:0] raw_ma = {2'b00, input_limit_field, 8'h00};
    wire logic [15:0] sum_ma = raw_ma > chg_pkg::LIMIT_CAP_MA ?
        chg_pkg::LIMIT_CAP_MA : raw_ma;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    //////////////////////////////////////////////////////////////////////
    a_field_decode: assert property (wr_lim ##1 ce |-> ##1
        input_limit_field == $past(field_in, 2)) else $error("field");
    a_limit_sum: assert property (input_limit_field != 6'h00 |->
        input_limit_ma == sum_ma) else $error("limit sum");
    a_low_floor: assert property (input_limit_field == 6'h00 |->
        input_limit_ma inside {16'h0000, 16'h0100}) else $error("floor");
    a_pin_follow: assert property ((ce && $stable(adapter_detect_input))[*7]
        |-> adapter_good_out_oe == !adapter_detect_input
        && !adapter_good_out_o) else $error("adapter pin");
    a_flags_gate: assert property ((ce && bad)[*4]
        |-> !charge_enable) else $error("flags");
    a_zero_stop: assert property (wr_zero |-> ##[1:4]
        !charge_enable) else $error("zero setting");
    a_lowvdd_reset: assert property ((!vdd_good)[*4] |->
        input_limit_ma == 16'h0100 && !charge_enable) else $error("vdd");
    a_timeout_off: assert property (timed_out[*3] |->
        !charge_enable) else $error("timeout");
    a_por_values: assert property (disable iff (1'b0) (!nrst)[*2] |->
        input_limit_ma == 16'h0100 && !charge_enable && !timed_out)
        else $error("reset values");
    c_charge: cover property ($rose(charge_enable));
    c_timeout: cover property ($rose(timed_out));
    c_cap: cover property (input_limit_ma == chg_pkg::LIMIT_CAP_MA);
endmodule : chg_ctrl_properties

bind chg_ctrl chg_ctrl_properties #(.WDOG_CYCLES(WDOG_CYCLES)) i_props (
    .clk(clk), .nrst(nrst), .ce(ce), .vdd_good(vdd_good), .wr_en(wr_en),
    .wr_cmd(wr_cmd), .wr_data(wr_data),
    .adapter_detect_input(adapter_detect_input),
    .main_input_supply_good(main_input_supply_good),
    .gate_driver_regulator_good(gate_driver_regulator_good),
    .reference_good(reference_good), .headroom_ok(headroom_ok),
    .power_fail(power_fail), .input_limit_ma(input_limit_ma),
    .input_limit_field(input_limit_field), .charge_enable(charge_enable),
    .adapter_good_out_o(adapter_good_out_o),
    .adapter_good_out_oe(adapter_good_out_oe), .timed_out(timed_out));

// >>> chg_host.sv
`timescale 1ns/1ps
module chg_host (
    input  wire logic        clk,
    output logic             wr_en,
    output logic      [7:0]  wr_cmd,
    output logic      [15:0] wr_data
);
    initial begin
        wr_en = 1'b0;
        wr_cmd = 8'h00;
        wr_data = 16'h0000;
    end
    // one word per strobe; released lines show the inverse
    task automatic write(input logic [7:0] c, input logic [15:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        wr_cmd <= c;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        wr_cmd <= ~c;
        wr_data <= ~d;
    endtask : write
endmodule : chg_host

// >>> chg_ctrl_bench.sv
`timescale 1ns/1ps
module chg_ctrl_bench;
    localparam longint WDOG = 400;
    logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, vdd_good = 1'b1, adi = 1'b0;
    logic [4:0] good = 5'h1f;
    logic wr_en, charge_enable, ag_o, ag_oe, timed_out;
    logic [7:0] wr_cmd;
    logic [15:0] wr_data, ma;
    logic [5:0] field;
    int n_errors = 0, comparisons = 0, cyc = 0;
    always #4 clk = ~clk;
    chg_host i_host (.clk(clk), .wr_en(wr_en), .wr_cmd(wr_cmd),
        .wr_data(wr_data));
    chg_ctrl #(.WDOG_CYCLES(WDOG)) i_dut (.clk(clk), .nrst(nrst), .ce(ce),
        .vdd_good(vdd_good), .wr_en(wr_en), .wr_cmd(wr_cmd),
        .wr_data(wr_data), .adapter_detect_input(adi),
        .main_input_supply_good(good[0]),
        .gate_driver_regulator_good(good[1]), .reference_good(good[2]),
        .headroom_ok(good[3]), .power_fail(!good[4]),
        .input_limit_ma(ma), .input_limit_field(field),
        .charge_enable(charge_enable), .adapter_good_out_o(ag_o),
        .adapter_good_out_oe(ag_oe), .timed_out(timed_out));
    //////////////////////////////////////////////////////////////////////
    task complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            $display("[FAIL] %0t run hung", $time);
            complete_run();
        end
    end
    task check16(input logic [15:0] got, exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check16
    task check1(input logic got, exp, input string what);
        check16({15'h0000, got}, {15'h0000, exp}, what);
    endtask : check1
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task wait_en(input logic exp);
        for (int i = 0; i < 20 && charge_enable !== exp; i++) tick(1);
        check1(charge_enable, exp, "charge_enable");
    endtask : wait_en
    //////////////////////////////////////////////////////////////////////
    task t_reset;
        check16(ma, 16'h0100, "reset limit");
        check16({10'h000, field}, 16'h0001, "reset field");
        check1(charge_enable, 1'b0, "reset enable");
        check1(ag_oe, 1'b1, "reset pin");
        $display("t_reset done");
    endtask : t_reset
    task automatic t_limit;
        logic [15:0] w [9] = '{16'h0000, 16'h0001, 16'h007f, 16'h0080,
            16'h1000, 16'h1500, 16'h1580, 16'h1f80, 16'he17f};
        logic [15:0] e;
        foreach (w[i]) begin
            i_host.write(8'h3f, w[i]);
            tick(2);
            e = {2'b00, w[i][12:7], 8'h00};
            if (e > chg_pkg::LIMIT_CAP_MA) e = chg_pkg::LIMIT_CAP_MA;
            if (w[i][12:7] == 6'h00 && w[i] != 16'h0000) e = 16'h0100;
            check16(ma, e, "limit");
            check16({10'h000, field}, {10'h000, w[i][12:7]}, "field");
        end
        $display("t_limit done");
    endtask : t_limit
    task t_adapter;
        @(posedge clk) adi <= 1'b1;
        tick(6);
        check1(ag_oe, 1'b0, "pin released");
        check1(ag_o, 1'b0, "pin level");
        @(posedge clk) adi <= 1'b0;
        tick(6);
        check1(ag_oe, 1'b1, "pin pulled");
        $display("t_adapter done");
    endtask : t_adapter
    task t_charge;
        i_host.write(8'h14, 16'h0400);
        tick(6);
        check1(charge_enable, 1'b0, "one setting");
        i_host.write(8'h15, 16'h3000);
        wait_en(1'b1);
        for (int k = 0; k < 5; k++) begin
            @(posedge clk) good <= 5'h1f ^ (5'h01 << k);
            tick(6);
            check1(charge_enable, 1'b0, "drop");
            @(posedge clk) good <= 5'h1f;
            wait_en(1'b1);
        end
        i_host.write(8'h15, 16'h0000);
        wait_en(1'b0);
        i_host.write(8'h15, 16'h3000);
        wait_en(1'b1);
        $display("t_charge done");
    endtask : t_charge
    task t_timeout;
        tick(int'(WDOG) + 10);
        check1(timed_out, 1'b1, "timed out");
        check1(charge_enable, 1'b0, "timeout stop");
        i_host.write(8'h14, 16'h0400);
        tick(6);
        check1(charge_enable, 1'b0, "half rewrite");
        i_host.write(8'h15, 16'h3000);
        wait_en(1'b1);
        check1(timed_out, 1'b0, "timeout cleared");
        $display("t_timeout done");
    endtask : t_timeout
    task t_persist;
        i_host.write(8'h3f, 16'h0800);
        @(posedge clk) ce <= 1'b0;
        i_host.write(8'h3f, 16'h0100);
        @(posedge clk) ce <= 1'b1;
        i_host.write(8'h16, 16'h1f80);
        @(posedge clk) good <= 5'h1e;
        tick(6);
        check16(ma, 16'h1000, "kept limit");
        @(posedge clk) vdd_good <= 1'b0;
        good <= 5'h1f;
        i_host.write(8'h3f, 16'h1f80);
        tick(4);
        @(posedge clk) vdd_good <= 1'b1;
        tick(4);
        check16(ma, 16'h0100, "vdd low limit");
        check1(charge_enable, 1'b0, "vdd low enable");
        $display("t_persist done");
    endtask : t_persist
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        tick(3);
        t_reset();
        t_limit();
        t_adapter();
        t_charge();
        t_timeout();
        t_persist();
        complete_run();
    end
endmodule : chg_ctrl_bench
